//--- verilog/adcsq_top.sv
`timescale 1ns/1ns
// How it works
// - A set pin enable bit routes its port pin to the converter.
// - Upper four bits of the pin enable register read as zero.
// - Start bit pulsed high then low begins one conversion.
// - Start held high while powered keeps converter in reset, pending flag at one.
// - Pending flag clears itself when a conversion finishes.
// - Each finish sets the interrupt flag; output only when unmasked.
// - Divider select 0..6 divides by 1..64; code 7 also divides by 64.
// - Converter powered only while the power down bit is zero.
// - Reference select high uses external pin, low uses supply.
// - A conversion ends after sixteen conversion clock periods.
// - Analog pins drop their pull-up and force input direction.
// - Result is twelve bits, read as low and high registers.
// - Divider select sits in bits two to zero of control one.
module adcsq_top
	import adcsq_pkg::*;
(
	// Clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	// Wishbone slave
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [adcsq_pkg::WB_AW-1:0] wb_adr_i,
	input  wire logic [adcsq_pkg::WB_SW-1:0] wb_sel_i,
	input  wire logic [adcsq_pkg::WB_DW-1:0] wb_dat_i,
	output logic      [adcsq_pkg::WB_DW-1:0] wb_dat_o,
	output logic                             wb_ack_o,
	// Interrupt
	output logic                             irq,
	// Shared port pins
	input  wire adcsq_pkg::adcsq_pin_in_s    pin_in,
	output adcsq_pkg::adcsq_pin_out_s        pin_out,
	output logic                             ref_pin_shared_dis,
	// Analog conversion core
	input  wire logic [adcsq_pkg::RES_W-1:0] core_result,
	output adcsq_pkg::adcsq_core_s           core_ctl
);
	// Whole register state of the block
	typedef struct packed {
		logic [3:0]        pin_en;
		logic              start;
		logic              pwrdn;
		logic              refsel;
		logic [2:0]        div_sel;
		adcsq_state_e      st;
		logic [4:0]        tick_cnt;
		logic [RES_W-1:0]  result;
		logic              irq_stat;
		logic              irq_mask;
		logic              ack;
		logic [WB_DW-1:0]  dat;
	} adcsq_regs_s;

	adcsq_regs_s s_r;
	adcsq_regs_s s_nxt;

	logic       tick;
	logic       div_clr;
	logic       bus_req;
	logic       wr_lane0;
	logic       rd_stat;
	logic       done_evt;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic       pending;

	// Register read mux, used for every decoded read
	function automatic logic [7:0] read_reg(input logic [7:0] adr,
		input adcsq_regs_s r, input logic pend);
		logic [7:0] v;
		v = 8'h00;
		case (adr)
			// Only the low nibble exists; the rest reads back zero
			ADDR_PIN_EN:
			begin
				v[PIN_CNT-1:0] = r.pin_en;
			end
			ADDR_CTRL0:
			begin
				v[START_BIT] = r.start;
				v[PEND_BIT]  = pend;
				v[PWRDN_BIT] = r.pwrdn;
			end
			ADDR_CTRL1:
			begin
				v[REFSEL_BIT]            = r.refsel;
				v[DIV_LSB +: DIV_W]      = r.div_sel;
			end
			ADDR_RES_LO:
			begin
				v = r.result[RES_LO_W-1:0];
			end
			ADDR_RES_HI:
			begin
				v[RES_HI_W-1:0] = r.result[RES_W-1:RES_LO_W];
			end
			ADDR_IRQ_STAT:
			begin
				v[IRQ_DONE_BIT] = r.irq_stat;
			end
			ADDR_IRQ_MASK:
			begin
				v[IRQ_DONE_BIT] = r.irq_mask;
			end
			default:
			begin
				v = 8'h00;
			end
		endcase
		return v;
	endfunction

	// Busy whenever the sequencer has left idle
	assign pending = (s_r.st != ADCSQ_IDLE);

	// Divider runs only while a conversion counts
	assign div_clr = (s_r.st != ADCSQ_CONV);

	adcsq_clkdiv u_clkdiv (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clr     (div_clr),
		.div_sel (s_r.div_sel),
		.tick    (tick)
	);

	adcsq_pinmux u_pinmux (
		.pin_analog_select_bits (s_r.pin_en),
		.pin_in                 (pin_in),
		.pin_out                (pin_out)
	);

	// Bus request accepted once; ack drops the cycle after
	assign bus_req  = wb_cyc_i && wb_stb_i && !s_r.ack;
	assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
	assign rd_stat  = bus_req && !wb_we_i && (wb_adr_i == ADDR_IRQ_STAT);
	assign wbyte    = wb_dat_i[7:0];
	assign rbyte    = read_reg(wb_adr_i, s_r, pending);

	// Next state: bus writes, sequencer, interrupt
	always_comb
	begin
		s_nxt    = s_r;
		done_evt = 1'b0;

		// Bus handshake and registered read data
		s_nxt.ack = bus_req;
		if (bus_req)
			s_nxt.dat = {{(WB_DW-8){1'b0}}, rbyte};

		// Software writes, low byte lane only
		if (wr_lane0)
		begin
			case (wb_adr_i)
				ADDR_PIN_EN:
				begin
					s_nxt.pin_en = wbyte[PIN_CNT-1:0];
				end
				ADDR_CTRL0:
				begin
					s_nxt.start = wbyte[START_BIT];
					s_nxt.pwrdn = wbyte[PWRDN_BIT];
				end
				ADDR_CTRL1:
				begin
					s_nxt.refsel  = wbyte[REFSEL_BIT];
					s_nxt.div_sel = wbyte[DIV_LSB +: DIV_W];
				end
				ADDR_IRQ_MASK:
				begin
					s_nxt.irq_mask = wbyte[IRQ_DONE_BIT];
				end
				default:
				begin
					s_nxt.irq_mask = s_r.irq_mask;
				end
			endcase
		end

		// Sequencer follows the current start bit value
		case (s_r.st)
			ADCSQ_IDLE:
			begin
				s_nxt.tick_cnt = 5'h00;
				// Start high while powered enters reset hold
				if (s_r.start && !s_r.pwrdn)
					s_nxt.st = ADCSQ_HELD;
			end
			ADCSQ_HELD:
			begin
				s_nxt.tick_cnt = 5'h00;
				// Falling start releases the conversion
				if (!s_r.start)
					s_nxt.st = ADCSQ_CONV;
			end
			ADCSQ_CONV:
			begin
				if (s_r.start)
				begin
					// New rising start restarts from reset
					s_nxt.st = ADCSQ_HELD;
				end
				else if (s_r.pwrdn)
				begin
					// Power loss aborts; no result, no interrupt
					s_nxt.st = ADCSQ_IDLE;
				end
				else if (tick)
				begin
					if (s_r.tick_cnt == CONV_LAST)
					begin
						s_nxt.st     = ADCSQ_IDLE;
						s_nxt.result = core_result;
						done_evt     = 1'b1;
					end
					else
					begin
						s_nxt.tick_cnt = s_r.tick_cnt + 5'h01;
					end
				end
			end
			default:
			begin
				s_nxt.st = ADCSQ_IDLE;
			end
		endcase

		// Power down wins over any start or hold, in the same edge,
		// so the core is never busy or ticking while it is off
		if (s_nxt.pwrdn)
		begin
			s_nxt.st       = ADCSQ_IDLE;
			s_nxt.tick_cnt = 5'h00;
		end

		// Sticky done flag; a new event beats the read clear
		if (done_evt)
			s_nxt.irq_stat = 1'b1;
		else if (rd_stat)
			s_nxt.irq_stat = 1'b0;
	end

	// State register with documented reset values
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_r          <= '0;
			s_r.pin_en   <= PIN_EN_RST;
			s_r.pwrdn    <= PWRDN_RST;
			s_r.div_sel  <= DIV_RST;
			s_r.st       <= ADCSQ_IDLE;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// Bus outputs straight from flops
	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.dat;

	// Level interrupt, only while enabled
	assign irq = s_r.irq_stat && s_r.irq_mask;

	// Reference pin gives up its other functions when selected
	assign ref_pin_shared_dis = s_r.refsel;

	// Core controls; reset holds while start stays high
	assign core_ctl.power_on = !s_r.pwrdn;
	assign core_ctl.reset    = (s_r.st == ADCSQ_HELD) || s_r.pwrdn;
	assign core_ctl.clk_tick = tick;
	assign core_ctl.ref_ext  = s_r.refsel;
	assign core_ctl.busy     = pending;
endmodule

//--- verilog/adcsq_pkg.sv
package adcsq_pkg;

	// Register byte addresses, one aligned word each
	localparam logic [7:0] ADDR_PIN_EN   = 8'h00;
	localparam logic [7:0] ADDR_CTRL0    = 8'h04;
	localparam logic [7:0] ADDR_CTRL1    = 8'h08;
	localparam logic [7:0] ADDR_RES_LO   = 8'h0C;
	localparam logic [7:0] ADDR_RES_HI   = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

	// Bus widths
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;
	localparam int WB_SW = 4;

	// Analog pin enable register
	localparam int         PIN_CNT    = 4;
	localparam logic [3:0] PIN_EN_RST = 4'hF;

	// Control register zero bit positions
	localparam int   START_BIT  = 7;
	localparam int   PEND_BIT   = 6;
	localparam int   PWRDN_BIT  = 5;
	localparam logic PWRDN_RST  = 1'h1;

	// Control register one bit positions
	localparam int         REFSEL_BIT = 4;
	localparam int         DIV_LSB    = 0;
	localparam int         DIV_W      = 3;
	localparam logic [2:0] DIV_RST    = 3'h0;

	// Result layout: low byte, then the top nibble
	localparam int RES_W    = 12;
	localparam int RES_LO_W = 8;
	localparam int RES_HI_W = RES_W - RES_LO_W;

	// Interrupt status and mask layout
	localparam int IRQ_DONE_BIT = 0;

	// Conversion length in conversion clock periods
	localparam int         CONV_TICKS = 16;
	localparam int         CNT_W      = 5;
	localparam logic [4:0] CONV_LAST  = CNT_W'(CONV_TICKS - 1);

	// Divider counter width covers divide by 64
	localparam int         DCNT_W     = 6;
	localparam logic [2:0] DIV_UNDEF  = 3'h7;
	localparam logic [5:0] DIV_MAXLIM = 6'h3F;

	// Sequencer states
	typedef enum logic [1:0] {
		ADCSQ_IDLE = 2'b00,
		ADCSQ_HELD = 2'b01,
		ADCSQ_CONV = 2'b10
	} adcsq_state_e;

	// Port side inputs from the ordinary I/O logic
	typedef struct packed {
		logic [PIN_CNT-1:0] pullup_req;
		logic [PIN_CNT-1:0] dir_input;
	} adcsq_pin_in_s;

	// Resulting pin configuration
	typedef struct packed {
		logic [PIN_CNT-1:0] analog_sel;
		logic [PIN_CNT-1:0] pullup_on;
		logic [PIN_CNT-1:0] dir_input;
		logic [PIN_CNT-1:0] digital_en;
	} adcsq_pin_out_s;

	// Controls toward the analog conversion core
	typedef struct packed {
		logic power_on;
		logic reset;
		logic clk_tick;
		logic ref_ext;
		logic busy;
	} adcsq_core_s;

	// Terminal count of the divider for a select code
	function automatic logic [5:0] div_limit(input logic [2:0] sel);
		logic [5:0] lim;
		lim = 6'h0;
		if (sel == DIV_UNDEF)
			lim = DIV_MAXLIM;
		else
			lim = DCNT_W'((7'h01 << sel) - 7'h01);
		return lim;
	endfunction

endpackage

//--- verilog/adcsq_clkdiv.sv
`timescale 1ns/1ns
module adcsq_clkdiv
	import adcsq_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Control
	input  wire logic        clr,
	input  wire logic [2:0]  div_sel,
	// Conversion clock tick
	output logic             tick
);
	typedef struct packed {
		logic [5:0] cnt;
	} adcsq_div_s;

	adcsq_div_s s_r;
	adcsq_div_s s_nxt;
	logic [5:0] lim;

	// Tick on terminal count; cleared so each conversion starts aligned
	always_comb
	begin
		lim   = div_limit(div_sel);
		tick  = !clr && (s_r.cnt >= lim); // Guards a shrinking divider
		s_nxt = s_r;
		if (clr || tick)
			s_nxt.cnt = 6'h0;
		else
			s_nxt.cnt = s_r.cnt + 6'h1;
	end

	// State register
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule

//--- verilog/adcsq_pinmux.sv
`timescale 1ns/1ns
module adcsq_pinmux
	import adcsq_pkg::*;
(
	// Analog enables
	input  wire logic [3:0]          pin_analog_select_bits,
	// Port side requests and resulting pin setup
	input  wire adcsq_pkg::adcsq_pin_in_s  pin_in,
	output adcsq_pkg::adcsq_pin_out_s      pin_out
);
	// One identical slice per shared port pin
	genvar i;
	generate
		for (i = 0; i < PIN_CNT; i++)
		begin : g_pin
			assign pin_out.analog_sel[i] = pin_analog_select_bits[i];
			assign pin_out.digital_en[i] = !pin_analog_select_bits[i];
			assign pin_out.pullup_on[i]  = pin_in.pullup_req[i]
				&& !pin_analog_select_bits[i];
			assign pin_out.dir_input[i]  = pin_in.dir_input[i]
				|| pin_analog_select_bits[i];
		end
	endgenerate
endmodule

//--- test/adcsq_assertions.sv
`timescale 1ns/1ns
module adcsq_assertions
	import adcsq_pkg::*;
(
	// Clock, reset and bus
	input wire logic                        sys_clk,
	input wire logic                        rst,
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_we_i,
	input wire logic [adcsq_pkg::WB_AW-1:0] wb_adr_i,
	input wire logic [adcsq_pkg::WB_SW-1:0] wb_sel_i,
	input wire logic [adcsq_pkg::WB_DW-1:0] wb_dat_i,
	input wire logic                        wb_ack_o,
	input wire logic                        irq,
	// Pins and core
	input wire adcsq_pkg::adcsq_pin_in_s    pin_in,
	input wire adcsq_pkg::adcsq_pin_out_s   pin_out,
	input wire logic                        ref_pin_shared_dis,
	input wire adcsq_pkg::adcsq_core_s      core_ctl
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Request taken, then a start write while powered
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_start;
		s_req ##0 wb_we_i && wb_adr_i == ADDR_CTRL0 && wb_sel_i[0]
			&& wb_dat_i[START_BIT] && !wb_dat_i[PWRDN_BIT]
			&& core_ctl.power_on;
	endsequence
	AST_ACK_NEXT: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse after request");
	AST_HOLD: assert property (s_start |=> ##[0:1]
		(core_ctl.busy && core_ctl.reset))
		else $error("start did not hold converter in reset");
	AST_DIG: assert property (pin_out.digital_en == ~pin_out.analog_sel)
		else $error("digital enable not inverse of analog select");
	AST_PULL: assert property (pin_out.pullup_on ==
		(pin_in.pullup_req & ~pin_out.analog_sel))
		else $error("pull-up kept on analog pin");
	AST_DIR: assert property (pin_out.dir_input ==
		(pin_in.dir_input | pin_out.analog_sel))
		else $error("direction not overridden on analog pin");
	AST_REF: assert property (core_ctl.ref_ext == ref_pin_shared_dis)
		else $error("reference pin sharing disagrees with source");
	AST_PWR: assert property (!core_ctl.power_on |->
		core_ctl.reset && !core_ctl.busy)
		else $error("converter active while powered down");
	AST_TICK: assert property (core_ctl.clk_tick |->
		core_ctl.busy && !core_ctl.reset)
		else $error("conversion tick outside a conversion");
	AST_END: assert property ($fell(core_ctl.busy) && core_ctl.power_on
		|-> $past(core_ctl.clk_tick))
		else $error("pending flag fell without a final tick");
	AST_IRQ_SET: assert property ($rose(irq) |->
		$past(core_ctl.clk_tick) || $past(wb_cyc_i && wb_stb_i
		&& wb_we_i && wb_adr_i == ADDR_IRQ_MASK))
		else $error("interrupt rose without a finish or mask write");
endmodule

bind adcsq_top adcsq_assertions i_chk (.sys_clk, .rst, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
	.irq, .pin_in, .pin_out, .ref_pin_shared_dis, .core_ctl);

//--- test/adcsq_core_model.sv
`timescale 1ns/1ns
module adcsq_core_model
	import adcsq_pkg::*;
(
	// Clock and controls
	input wire logic                        sys_clk,
	input wire adcsq_pkg::adcsq_core_s      core_ctl,
	// Result and the code it settles to
	output logic [adcsq_pkg::RES_W-1:0]     core_result,
	output logic [adcsq_pkg::RES_W-1:0]     final_res
);
	logic [4:0]       ticks = 5'h00;
	logic [RES_W-1:0] junk  = 12'h5A5;
	logic [RES_W-1:0] code  = 12'hFFF;
	// Code valid only after fifteen ticks, churning otherwise
	assign core_result = (ticks == 5'h0F) ? code : junk;
	assign final_res   = code;
	// New code picked while held, so no stale value survives
	always_ff @(posedge sys_clk)
	begin
		junk <= ~junk;
		if (core_ctl.reset)
		begin
			ticks <= 5'h00;
			code  <= code + 12'h3B7;
		end
		else if (core_ctl.clk_tick)
			ticks <= ticks + 5'h01;
	end
endmodule

//--- test/testbench.sv
`timescale 1ns/1ns
module testbench;
	import adcsq_pkg::*;
	// Clock, reset and bus
	logic           sys_clk = 1'b0;
	logic           rst = 1'b1;
	logic           cyc = 1'b0;
	logic           stb = 1'b0;
	logic           we = 1'b0;
	logic [7:0]     adr = 8'h00;
	logic [3:0]     sel = 4'h0;
	logic [31:0]    dat = 32'h0;
	logic [31:0]    dat_o;
	logic           ack;
	logic           irq;
	logic           ref_dis;
	// Pins and core
	adcsq_pin_in_s  pin_in = 8'h00;
	adcsq_pin_out_s pin_out;
	adcsq_core_s    core_ctl;
	logic [11:0]    res;
	logic [11:0]    fin;
	// Bookkeeping
	int             err_count = 0;
	int             cmp_count = 0;
	int             cyc_n = 0;
	int             ticks = 0;
	logic [31:0]    q;
	// Power-up settling wait before a start; length is arbitrary
	localparam int  SETTLE_CYC = 8;

	adcsq_top i_adcsq_top (.sys_clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .irq, .pin_in, .pin_out,
		.ref_pin_shared_dis(ref_dis), .core_result(res), .core_ctl);
	adcsq_core_model i_adcsq_core_model (.sys_clk, .core_ctl,
		.core_result(res), .final_res(fin));

	// Free running clock
	initial
	begin
		forever #10 sys_clk = ~sys_clk;
	end

	// Tick count and hang guard
	always @(posedge sys_clk)
	begin
		cyc_n++;
		if (core_ctl.clk_tick === 1'b1)
			ticks++;
		if (cyc_n == 20000)
		begin
			err_count++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic rng(input string nm, input int lo, input int hi,
		input int g);
		cmp_count++;
		if (g < lo || g > hi)
		begin
			err_count++;
			$display("mismatch %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask

	// One classic cycle; waits for ack, then idles a cycle
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= {24'h0, d};
		do @(posedge sys_clk); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic t_regs();
		bus(0, ADDR_PIN_EN, 8'h00);
		chk("pin_en_rst", 32'h0F, q);
		bus(0, ADDR_CTRL0, 8'h00);
		chk("ctrl0_rst", 32'h20, q);
		chk("pins_rst", 16'hF0F0, pin_out);
		bus(1, ADDR_PIN_EN, 8'hF5);
		bus(0, ADDR_PIN_EN, 8'h00);
		chk("pin_en_hi", 32'h05, q);
		pin_in <= 8'hF0;
		@(posedge sys_clk);
		chk("pins_mix", 16'h5A5A, pin_out);
		bus(0, 8'h1C, 8'h00);
		chk("unmapped", 32'h0, q);
		bus(1, ADDR_CTRL1, 8'h10);
		chk("ref_sel", 32'h1, ref_dis);
		bus(0, ADDR_CTRL1, 8'h00);
		chk("ctrl1", 32'h10, q);
		$display("test regs done");
	endtask

	task automatic t_conv(input logic [2:0] s, input logic m);
		int n;
		int t0;
		n = (s == 3'h7) ? 64 : (1 << s);
		bus(1, ADDR_IRQ_MASK, {7'h0, m});
		bus(1, ADDR_CTRL1, {5'h0, s});
		chk("ref_sup", 32'h0, ref_dis);
		bus(1, ADDR_CTRL0, 8'h00);
		repeat (SETTLE_CYC) @(posedge sys_clk);
		bus(1, ADDR_CTRL0, 8'h80);
		chk("held", 2'b11, {core_ctl.busy, core_ctl.reset});
		bus(0, ADDR_CTRL0, 8'h00);
		chk("pend_held", 1'b1, q[PEND_BIT]);
		ticks = 0;
		t0 = cyc_n;
		bus(1, ADDR_CTRL0, 8'h00);
		while (core_ctl.busy === 1'b1)
			@(posedge sys_clk);
		rng("conv_len", 16 * n, 16 * n + 4, cyc_n - t0);
		chk("ticks", 16, ticks);
		chk("irq", m, irq);
		bus(0, ADDR_CTRL0, 8'h00);
		chk("pend_clr", 1'b0, q[PEND_BIT]);
		bus(0, ADDR_RES_LO, 8'h00);
		chk("res_lo", fin[7:0], q);
		bus(0, ADDR_RES_HI, 8'h00);
		chk("res_hi", fin[11:8], q);
		bus(0, ADDR_IRQ_STAT, 8'h00);
		chk("stat", 32'h1, q);
		chk("irq_clr", 1'b0, irq);
		$display("test conv %0d done", s);
	endtask

	task automatic t_pwr();
		bus(1, ADDR_CTRL0, 8'h80);
		bus(1, ADDR_CTRL0, 8'h00);
		bus(1, ADDR_CTRL0, 8'h80);
		chk("restart", 2'b11, {core_ctl.busy, core_ctl.reset});
		bus(1, ADDR_CTRL0, 8'h00);
		chk("reconv", 1'b1, core_ctl.busy);
		bus(1, ADDR_CTRL0, 8'h20);
		chk("abort", 3'b010, {core_ctl.power_on, core_ctl.reset,
			core_ctl.busy});
		bus(0, ADDR_IRQ_STAT, 8'h00);
		chk("abort_stat", 32'h0, q);
		bus(1, ADDR_CTRL0, 8'hA0);
		chk("no_start", 1'b0, core_ctl.busy);
		$display("test power done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_regs();
		// Whole divider sweep; at 50 MHz only codes 5 to 7 keep the
		// conversion clock period inside its limits
		for (int s = 0; s < 8; s++)
			t_conv(s[2:0], s[0]);
		t_pwr();
		report_and_stop();
	end
endmodule
